// >>> sfefp_map.svh
`ifndef SFEFP_MAP_SVH
`define SFEFP_MAP_SVH
`define SFEFP_FRAME_LEN    8'd160
`define SFEFP_SUBSEG_LEN   6'd40
`define SFEFP_SUBSEG_CNT   3'd4
`define SFEFP_HOME_SAMPLE  16'h0008
`define SFEFP_FILT_COEF    16'h7FDF
`define SFEFP_ROUND_15     32'h0000_4000
`define SFEFP_MAX16        16'h7FFF
`define SFEFP_MIN16        16'h8000
`define SFEFP_MAX32        32'h7FFF_FFFF
`define SFEFP_MIN32        32'h8000_0000
`define SFEFP_DOWN_RIGHT   8'sh03
`define SFEFP_DOWN_LEFT    8'sh02
`define SFEFP_FRAC_SHIFT   8'sh0F
`define SFEFP_FIFO_DEPTH   32
`endif

// >>> sfefp_pkg.sv
package sfefp_pkg;
  typedef logic signed [15:0] sfefp_word_type;
  typedef logic signed [31:0] sfefp_long_type;
  typedef struct packed {
    logic           frame_start;
    logic [1:0]     subseg;
    sfefp_word_type sample;
  } sfefp_sample_type;
endpackage

// >>> sfefp_fifo.sv
`timescale 1ns/1ps
module sfefp_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> sfefp_top.sv
`timescale 1ns/1ps
`include "sfefp_map.svh"
module sfefp_top #(
  parameter int FIFO_DEPTH = `SFEFP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_reset_n,
  // Sample source
  input  wire logic                       i_in_valid,
  input  wire logic                       i_in_frame_start,
  input  wire sfefp_pkg::sfefp_word_type  i_in_sample,
  output logic                            o_in_ready,
  // Filtered sample stream to later stages
  output logic                            o_out_valid,
  output sfefp_pkg::sfefp_sample_type     o_out_data,
  input  wire logic                       i_out_ready,
  // Status
  output logic                            o_homed
);
  import sfefp_pkg::*;

  // Saturating primitives
  function automatic sfefp_word_type sat16(input logic signed [16:0] v);
    if (v > 17'sd32767) begin
      return `SFEFP_MAX16;
    end else if (v < -17'sd32768) begin
      return `SFEFP_MIN16;
    end
    return v[15:0];
  endfunction

  function automatic sfefp_word_type add16(input sfefp_word_type a, input sfefp_word_type b);
    return sat16(17'(a) + 17'(b));
  endfunction

  function automatic sfefp_word_type sub16(input sfefp_word_type a, input sfefp_word_type b);
    return sat16(17'(a) - 17'(b));
  endfunction

  function automatic sfefp_long_type sat32(input logic signed [32:0] v);
    logic signed [32:0] hi;
    logic signed [32:0] lo;
    hi = 33'(signed'(`SFEFP_MAX32));
    lo = -33'sd2147483648;
    if (v > hi) begin
      return `SFEFP_MAX32;
    end else if (v < lo) begin
      return `SFEFP_MIN32;
    end
    return v[31:0];
  endfunction

  function automatic sfefp_long_type ladd(input sfefp_long_type a, input sfefp_long_type b);
    return sat32(33'(a) + 33'(b));
  endfunction

  function automatic sfefp_long_type lsub(input sfefp_long_type a, input sfefp_long_type b);
    return sat32(33'(a) - 33'(b));
  endfunction

  function automatic sfefp_word_type mult(input sfefp_word_type a, input sfefp_word_type b);
    sfefp_long_type p;
    p = a * b;
    if (a == `SFEFP_MIN16 && b == `SFEFP_MIN16) begin
      return `SFEFP_MAX16;
    end
    return 16'(p >>> `SFEFP_FRAC_SHIFT);
  endfunction

  function automatic sfefp_word_type mult_r(input sfefp_word_type a, input sfefp_word_type b);
    sfefp_long_type p;
    p = a * b;
    if (a == `SFEFP_MIN16 && b == `SFEFP_MIN16) begin
      return `SFEFP_MAX16;
    end
    return 16'((p + `SFEFP_ROUND_15) >>> `SFEFP_FRAC_SHIFT);
  endfunction

  function automatic sfefp_word_type abs16(input sfefp_word_type a);
    if (a == `SFEFP_MIN16) begin
      return `SFEFP_MAX16;
    end
    return (a < 0) ? -a : a;
  endfunction

  // Restoring division; numerator not above denominator, both positive
  function automatic sfefp_word_type div16(input sfefp_word_type num, input sfefp_word_type den);
    sfefp_long_type  r;
    sfefp_word_type  q;
    if (num == den) begin
      return `SFEFP_MAX16;
    end
    r = 32'(num);
    q = '0;
    for (int i = 0; i < 15; i++) begin
      r = r <<< 1;
      q = q <<< 1;
      if (r >= 32'(den)) begin
        r = r - 32'(den);
        q = q + 16'sd1;
      end
    end
    return q;
  endfunction

  function automatic sfefp_long_type lmult(input sfefp_word_type a, input sfefp_word_type b);
    sfefp_long_type p;
    p = a * b;
    return p <<< 1;
  endfunction

  // Signed shift counts; negative flips direction
  function automatic sfefp_long_type lshl(input sfefp_long_type v, input logic signed [7:0] n);
    return (n < 0) ? (v >>> (-n)) : (v <<< n);
  endfunction

  function automatic sfefp_long_type lshr(input sfefp_long_type v, input logic signed [7:0] n);
    return (n < 0) ? (v <<< (-n)) : (v >>> n);
  endfunction

  function automatic sfefp_word_type shl16(input sfefp_word_type v, input logic signed [7:0] n);
    return (n < 0) ? (v >>> (-n)) : (v <<< n);
  endfunction

  function automatic sfefp_word_type shr16(input sfefp_word_type v, input logic signed [7:0] n);
    return (n < 0) ? (v <<< (-n)) : (v >>> n);
  endfunction

  // Input capture stage
  logic           cap_valid_reg;
  logic           cap_start_reg;
  sfefp_word_type cap_sample_reg;
  logic           fifo_in_ready;
  logic           take;

  // Take only on a handshake; ready high implies the capture stage is empty
  assign take = i_in_valid && o_in_ready;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cap_valid_reg  <= 1'b0;
      cap_start_reg  <= 1'b0;
      cap_sample_reg <= '0;
    end else if (take) begin
      cap_valid_reg  <= 1'b1;
      cap_start_reg  <= i_in_frame_start;
      cap_sample_reg <= i_in_sample;
    end else if (fifo_in_ready) begin
      cap_valid_reg  <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_in_ready <= 1'b0;
    end else begin
      o_in_ready <= !cap_valid_reg && !take && fifo_in_ready;
    end
  end

  // Frame position
  logic [7:0] pos_reg;
  logic       aligned_reg;
  logic       all_home_reg;
  logic       step;
  logic       frame_first;
  logic       frame_last;

  assign step        = cap_valid_reg && fifo_in_ready;
  assign frame_first = cap_start_reg || (pos_reg == 8'd0);
  assign frame_last  = (cap_start_reg ? 8'd0 : pos_reg) == `SFEFP_FRAME_LEN - 8'd1;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pos_reg <= '0;
    end else if (step) begin
      if (frame_last) begin
        pos_reg <= '0;
      end else begin
        pos_reg <= (cap_start_reg ? 8'd0 : pos_reg) + 8'd1;
      end
    end
  end

  // Homing detect on valid sample bits only; don't-care bits may be random
  logic is_home;
  assign is_home = (cap_sample_reg[15:3] == 13'(`SFEFP_HOME_SAMPLE >> 3));

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aligned_reg  <= 1'b0;
      all_home_reg <= 1'b0;
    end else if (step) begin
      if (frame_first) begin
        aligned_reg  <= cap_start_reg;
        all_home_reg <= is_home;
      end else begin
        all_home_reg <= all_home_reg && is_home;
      end
    end
  end

  logic home_now;
  assign home_now = step && frame_last && !frame_first && aligned_reg && all_home_reg &&
                    is_home;

  // Offset compensation filter datapath
  sfefp_word_type input_delay_reg;
  sfefp_long_type feedback_state_reg;
  sfefp_word_type sample_valid;
  sfefp_word_type downscaled;
  sfefp_word_type difference_term;
  sfefp_long_type feedback_sum;
  sfefp_word_type high_part;
  sfefp_long_type low_part;
  sfefp_word_type low_prod;
  sfefp_long_type feedback_state_next;
  sfefp_word_type filtered;

  always_comb begin
    sample_valid    = {cap_sample_reg[15:3], 3'b000};
    downscaled      = shl16(shr16(sample_valid, `SFEFP_DOWN_RIGHT), `SFEFP_DOWN_LEFT);
    difference_term = sub16(downscaled, input_delay_reg);
    feedback_sum    = lshl(32'(difference_term), `SFEFP_FRAC_SHIFT);
    high_part       = 16'(lshr(feedback_state_reg, `SFEFP_FRAC_SHIFT));
    low_part        = lsub(feedback_state_reg, lshl(32'(high_part), `SFEFP_FRAC_SHIFT));
    low_prod        = mult_r(16'(low_part), `SFEFP_FILT_COEF);
    feedback_sum    = ladd(feedback_sum, 32'(low_prod));
    feedback_state_next = ladd(lshr(lmult(high_part, `SFEFP_FILT_COEF), 8'sh01),
                               feedback_sum);
    filtered = 16'(lshr(ladd(feedback_state_next, `SFEFP_ROUND_15),
                        `SFEFP_FRAC_SHIFT));
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      input_delay_reg    <= '0;
      feedback_state_reg <= '0;
    end else if (home_now) begin
      input_delay_reg    <= '0;
      feedback_state_reg <= '0;
    end else if (step) begin
      input_delay_reg    <= downscaled;
      feedback_state_reg <= feedback_state_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_homed <= 1'b0;
    end else begin
      o_homed <= home_now;
    end
  end

  // Output buffer
  sfefp_sample_type fifo_in;
  sfefp_sample_type fifo_out;
  logic             fifo_out_valid;
  logic             pop;
  logic [7:0]       cur_pos;

  assign cur_pos             = cap_start_reg ? 8'd0 : pos_reg;
  assign fifo_in.frame_start = frame_first;
  assign fifo_in.subseg      = 2'(cur_pos / 8'(`SFEFP_SUBSEG_LEN));
  assign fifo_in.sample      = filtered;

  sfefp_fifo #(
    .WIDTH($bits(sfefp_sample_type)),
    .DEPTH(FIFO_DEPTH)
  ) sfefp_fifo_inst (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (cap_valid_reg),
    .i_in_data   (fifo_in),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out),
    .i_out_ready (pop)
  );

  // Registered output skid
  assign pop = fifo_out_valid && (!o_out_valid || i_out_ready);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
    end else if (pop) begin
      o_out_valid <= 1'b1;
      o_out_data  <= fifo_out;
    end else if (i_out_ready) begin
      o_out_valid <= 1'b0;
    end
  end
endmodule

// >>> sfefp_top_assertions.sv
`timescale 1ns/1ps
module sfefp_top_assertions (
  input wire logic                        i_clk,
  input wire logic                        i_reset_n,
  input wire logic                        i_in_valid,
  input wire logic                        o_in_ready,
  input wire logic                        o_out_valid,
  input wire sfefp_pkg::sfefp_sample_type o_out_data,
  input wire logic                        i_out_ready,
  input wire logic                        o_homed
);
  import sfefp_pkg::*;
  logic [7:0] pos_reg;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  // Position of the next delivered sample in its frame
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pos_reg <= 8'h00;
    end else if (o_out_valid && i_out_ready) begin
      pos_reg <= (pos_reg == 8'h9F) ? 8'h00 : pos_reg + 8'h01;
    end
  end
  out_hold_a: assert property (o_out_valid && !i_out_ready
    |=> o_out_valid && $stable(o_out_data)) else $error("output moved while stalled");
  out_release_a: assert property ($fell(o_out_valid)
    |-> $past(i_out_ready)) else $error("output dropped without ready");
  out_latency_a: assert property (i_in_valid && o_in_ready && !o_out_valid
    |-> ##[1:4] o_out_valid) else $error("taken sample not delivered in time");
  reset_quiet_a: assert property ($rose(i_reset_n)
    |-> !o_out_valid && !o_homed) else $error("outputs active after reset");
  ready_rise_a: assert property ($rose(i_reset_n)
    |-> !o_in_ready ##[1:2] o_in_ready) else $error("input ready late after reset");
  frame_mark_a: assert property (o_out_valid
    |-> o_out_data.frame_start == (pos_reg == 8'h00)) else $error("frame marker misplaced");
  subseg_pos_a: assert property (o_out_valid
    |-> o_out_data.subseg == pos_reg / 8'h28) else $error("sub-segment index wrong");
  homed_pulse_a: assert property (o_homed
    |=> !o_homed) else $error("homed flag longer than one cycle");
endmodule
bind sfefp_top sfefp_top_assertions sfefp_top_assertions_inst (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
  .o_out_valid(o_out_valid), .o_out_data(o_out_data), .i_out_ready(i_out_ready),
  .o_homed(o_homed));

// >>> sfefp_sink_model.sv
`timescale 1ns/1ps
module sfefp_sink_model (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_stall,
  output logic      o_ready
);
  logic [5:0] gap_reg;
  initial o_ready = 1'b0;
  initial gap_reg = 6'h00;
  // Stalled: one take in 64 cycles
  always @(negedge i_clk) begin
    gap_reg <= gap_reg + 6'h01;
    o_ready <= i_reset_n && (!i_stall || gap_reg == 6'h3F);
  end
endmodule

// >>> speech_frontend_fixed_point_test.sv
`timescale 1ns/1ps
`include "sfefp_map.svh"
module speech_frontend_fixed_point_test;
  import sfefp_pkg::*;
  logic             clk;
  logic             rst_n;
  logic             in_valid;
  logic             in_fs;
  logic             in_ready;
  logic             out_valid;
  logic             out_ready;
  logic             homed;
  logic             stall;
  logic             homed_seen;
  logic             blocked_seen;
  logic             home_reg;
  logic [15:0]      lfsr_reg;
  sfefp_word_type   in_sample;
  sfefp_word_type   z1_reg;
  sfefp_long_type   z2_reg;
  sfefp_sample_type out_data;
  sfefp_sample_type exp_q[$];
  int               n_errors;
  int               n_compared;

  sfefp_top sfefp_top_inst (
    .i_clk(clk), .i_reset_n(rst_n), .i_in_valid(in_valid), .i_in_frame_start(in_fs),
    .i_in_sample(in_sample), .o_in_ready(in_ready), .o_out_valid(out_valid),
    .o_out_data(out_data), .i_out_ready(out_ready), .o_homed(homed));
  sfefp_sink_model sfefp_sink_model_inst (
    .i_clk(clk), .i_reset_n(rst_n), .i_stall(stall), .o_ready(out_ready));

  function automatic longint sat(input longint v, input longint hi);
    return v > hi ? hi : (v < -hi - 1 ? -hi - 1 : v);
  endfunction

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic sfefp_sample_type expect_next(input logic [15:0] raw, input int pos);
    sfefp_word_type   so;
    sfefp_word_type   s1;
    sfefp_word_type   msp;
    sfefp_word_type   lsp;
    longint           acc;
    sfefp_sample_type e;
    if (pos == 0) home_reg = 1'b1;
    if ((raw >> 3) != (`SFEFP_HOME_SAMPLE >> 3)) home_reg = 1'b0;
    so = $signed(raw) >>> `SFEFP_DOWN_RIGHT;
    so = so << `SFEFP_DOWN_LEFT;
    s1 = 16'(sat(longint'(so) - z1_reg, `SFEFP_MAX16));
    z1_reg = so;
    msp = 16'(z2_reg >>> 15);
    lsp = 16'(sat(longint'(z2_reg) - (longint'(msp) <<< 15), `SFEFP_MAX32));
    acc = (longint'(lsp) * longint'(`SFEFP_FILT_COEF) + longint'(`SFEFP_ROUND_15)) >>> 15;
    acc = sat((longint'(s1) <<< 15) + acc, `SFEFP_MAX32);
    z2_reg = 32'(sat(longint'(msp) * longint'(`SFEFP_FILT_COEF) + acc, `SFEFP_MAX32));
    e.sample = 16'(sat(longint'(z2_reg) + longint'(`SFEFP_ROUND_15), `SFEFP_MAX32) >>> 15);
    e.frame_start = (pos == 0);
    e.subseg = 2'(pos / 40);
    if (pos == 159 && home_reg) begin
      z1_reg = '0;
      z2_reg = '0;
    end
    return e;
  endfunction

  task automatic test_done;
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic guard(input int n);
    if (n >= 20000) begin
      n_errors++;
      $display("BAD %0t wait ran out", $time);
      test_done();
    end
  endtask

  task automatic send(input logic [15:0] raw, input int pos);
    int n;
    n = 0;
    in_valid = 1'b1;
    in_fs = (pos == 0);
    in_sample = raw;
    while (!in_ready && n < 20000) begin
      n++;
      @(negedge clk);
    end
    guard(n);
    if (n > 8) blocked_seen = 1'b1;
    @(negedge clk);
    in_valid = 1'b0;
    exp_q.push_back(expect_next(raw, pos));
    @(negedge clk);
  endtask

  // kind 0 random, 1 full-scale swing, 2 homing pattern, 3 homing with junk low bits
  task automatic frame(input int kind);
    int n;
    homed_seen = 1'b0;
    for (int p = 0; p < 160; p++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      send(kind == 2 ? `SFEFP_HOME_SAMPLE : (kind == 3 ? {13'h0001, lfsr_reg[2:0]}
        : (kind == 1 ? (p[0] ? 16'h7FFF : 16'h8000) : lfsr_reg)), p);
    end
    n = 0;
    while (exp_q.size() != 0 && n < 20000) begin
      n++;
      @(negedge clk);
    end
    guard(n);
    repeat (8) @(negedge clk);
    n_compared++;
    if (homed_seen !== (kind >= 2)) begin
      n_errors++;
      $display("BAD %0t homing flag wrong", $time);
    end
  endtask

  always @(posedge clk) begin
    if (rst_n && out_valid === 1'b1 && out_ready) begin
      n_compared++;
      if (exp_q.size() == 0 || out_data !== exp_q[0]) begin
        n_errors++;
        $display("BAD %0t output sample differs", $time);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    if (homed === 1'b1) homed_seen = 1'b1;
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    in_valid = 1'b0;
    in_fs = 1'b0;
    in_sample = 16'h0000;
    stall = 1'b0;
    lfsr_reg = 16'h0034;
    z1_reg = '0;
    z2_reg = '0;
    home_reg = 1'b0;
    homed_seen = 1'b0;
    blocked_seen = 1'b0;
    n_errors = 0;
    n_compared = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    frame(0);
    frame(1);
    frame(2);
    frame(2);
    frame(3);
    frame(0);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    z1_reg = '0;
    z2_reg = '0;
    rst_n = 1'b1;
    frame(0);
    blocked_seen = 1'b0;
    stall = 1'b1;
    frame(0);
    n_compared++;
    if (blocked_seen !== 1'b1) begin
      n_errors++;
      $display("BAD %0t full buffer never refused", $time);
    end
    test_done();
  end
endmodule
